// ===== logic/bpss_map.vh
// constants for the board power state sequencer: state codes and timing counts
// assumes a 125 MHz system clock feeding the sequencer
`ifndef BPSS_MAP_VH
`define BPSS_MAP_VH

// ----------------------------------------------------------------------------
// power states
// ----------------------------------------------------------------------------
`define BPSS_ST_G3        3'h0
`define BPSS_ST_S0        3'h1
`define BPSS_ST_S3        3'h2
`define BPSS_ST_S4        3'h3
`define BPSS_ST_S5        3'h4

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define BPSS_OFS_STAT     4'h0
`define BPSS_OFS_MASK     4'h1
`define BPSS_OFS_STATE    4'h2

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BPSS_CLK_MHZ      125
`define BPSS_SHORT_S      4
`define BPSS_LONG_S       6
`define BPSS_DEB_US       10
`define BPSS_DEB_CYC      (`BPSS_DEB_US * `BPSS_CLK_MHZ)
`define BPSS_SHORT_CYC    (`BPSS_SHORT_S * `BPSS_CLK_MHZ * 1000000)
`define BPSS_LONG_CYC     (`BPSS_LONG_S * `BPSS_CLK_MHZ * 1000000)

// ----------------------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------------------
`define BPSS_EV_WAKE      0
`define BPSS_EV_SLEEP     1
`define BPSS_EV_FORCE     2
`define BPSS_EV_NUM       3

`endif

// ===== logic/bpss_seq.v
// board power state sequencer: switch timing, wake sources, restore policy, indicators
// assumes clk_sys runs from standby power and nrst is the standby-power reset
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "bpss_map.vh"

// Summary of operation
// - a press shorter than four seconds in soft-off or sleep brings the system to working.
// - a short press while working enters sleep or soft-off as the os setting input selects.
// - a press held beyond six seconds in working or sleep forces soft-off.
// - switch, alarm, network and pcie wake all wake the system from S3, S4 and S5; usb wake only as limited below.
// - usb wake is ignored in S4 and S5 unless the firmware option enables it.
// - usb wakes from S3 but stays disabled after mechanical-off until a normal power-up.
// - on return of ac power the on or off state held before is restored per policy.
// - a network wake-frame request powers the system up.
// - the active-low pcie wake line wakes the system from S3, S4 or S5.
// - the real-time-clock alarm wakes the system from S5.
// - in S3 only standby power stays on and the indicator shows amber or dark.
// - a wake in S3 resumes the last working state without a cold boot.
// - the standby indicator is lit whenever standby power is present.
// - an alarm wake keeps the display in its sleep state.
module bpss_seq (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // front panel and wake inputs (asynchronous pins)
  input  wire        pwr_sw_n,
  input  wire        rtc_alarm,
  input  wire        lan_wake,
  input  wire        usb_wake,
  input  wire        pcie_wake_n,
  // supply status and settings
  input  wire        ac_ok,
  input  wire        sleep_sel_s3,
  input  wire        usb_deep_en,
  input  wire        restore_on,
  input  wire        led_dual,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        irq,
  // power and indicators
  output reg  [2:0]  pwr_state,
  output reg         main_pwr_en,
  output reg         cold_boot,
  output reg         display_on,
  output reg         led_green,
  output reg         led_amber,
  output reg         led_stby
);

  // --------------------------------------------------------------------------
  // register offsets and timing counts
  // --------------------------------------------------------------------------
  localparam [3:0] OFS_STAT  = `BPSS_OFS_STAT;
  localparam [3:0] OFS_MASK  = `BPSS_OFS_MASK;
  localparam [3:0] OFS_STATE = `BPSS_OFS_STATE;
  localparam [31:0] DEB_CYC   = `BPSS_DEB_CYC;
  localparam [31:0] SHORT_CYC = `BPSS_SHORT_CYC;
  localparam [31:0] LONG_CYC  = `BPSS_LONG_CYC;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  localparam NIN = 5;
  wire [NIN-1:0] pin_raw;
  wire [NIN-1:0] pin_lvl;
  assign pin_raw = {~pcie_wake_n, usb_wake, lan_wake, rtc_alarm, ~pwr_sw_n};

  // three flops per pin; the level moves once the second and third agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg lvl;
      always @(posedge clk_sys) begin
        if (!nrst) begin
          s1  <= 1'b0;
          s2  <= 1'b0;
          s3  <= 1'b0;
          lvl <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            lvl <= s3;
        end
      end
      assign pin_lvl[gi] = lvl;
    end
  endgenerate

  // ac status: same three-flop treatment, kept apart for the restore logic
  reg ac1;
  reg ac2;
  reg ac3;
  reg ac_lvl;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ac1    <= 1'b0;
      ac2    <= 1'b0;
      ac3    <= 1'b0;
      ac_lvl <= 1'b0;
    end else begin
      ac1 <= ac_ok;
      ac2 <= ac1;
      ac3 <= ac2;
      if (ac2 == ac3)
        ac_lvl <= ac3;
    end
  end

  // --------------------------------------------------------------------------
  // switch debounce and press timer
  // --------------------------------------------------------------------------
  reg [31:0] deb_cnt;
  reg        sw_db;
  reg [31:0] press_cnt;
  reg        long_done;
  reg        sw_rel;
  reg        sw_long;
  reg        was_short;

  // debounce: the level must hold steady for the whole window; filters contact bounce
  always @(posedge clk_sys) begin
    if (!nrst) begin
      deb_cnt <= 32'h0000_0000;
      sw_db   <= 1'b0;
    end else if (pin_lvl[0] == sw_db) begin
      deb_cnt <= 32'h0000_0000;
    end else if (deb_cnt >= DEB_CYC - 32'h0000_0001) begin
      deb_cnt <= 32'h0000_0000;
      sw_db   <= pin_lvl[0];
    end else begin
      deb_cnt <= deb_cnt + 32'h0000_0001;
    end
  end

  // press duration; the long event fires once while still held, release pulses only
  // for presses under four seconds; presses between four and six seconds do nothing
  always @(posedge clk_sys) begin
    if (!nrst) begin
      press_cnt <= 32'h0000_0000;
      long_done <= 1'b0;
      sw_rel    <= 1'b0;
      sw_long   <= 1'b0;
    end else begin
      sw_rel  <= 1'b0;
      sw_long <= 1'b0;
      if (sw_db) begin
        if (press_cnt != 32'hFFFF_FFFF)
          press_cnt <= press_cnt + 32'h0000_0001;
        if (press_cnt >= LONG_CYC && !long_done) begin
          long_done <= 1'b1;
          sw_long   <= 1'b1;
        end
      end else begin
        if (press_cnt != 32'h0000_0000 && press_cnt < SHORT_CYC)
          sw_rel <= 1'b1;
        press_cnt <= 32'h0000_0000;
        long_done <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // wake edge detection: one event per assertion
  // --------------------------------------------------------------------------
  reg  [4:1] wk_q;
  wire [4:1] wk_rise;
  always @(posedge clk_sys) begin
    if (!nrst)
      wk_q <= 4'h0;
    else
      wk_q <= pin_lvl[4:1];
  end
  assign wk_rise = pin_lvl[4:1] & ~wk_q;

  reg  usb_blk;
  wire asleep;
  wire deep;
  wire usb_ok;
  wire wake_any;
  assign asleep   = (pwr_state == `BPSS_ST_S3) || (pwr_state == `BPSS_ST_S4) ||
                    (pwr_state == `BPSS_ST_S5);
  assign deep     = (pwr_state == `BPSS_ST_S4) || (pwr_state == `BPSS_ST_S5);
  assign usb_ok   = !usb_blk && (!deep || usb_deep_en);
  // network and pcie wake from any sleep state
  assign wake_any = asleep && (wk_rise[2] || wk_rise[4] || (wk_rise[3] && usb_ok) ||
                    wk_rise[1] || sw_rel);
  // the alarm is honoured in every sleep state, soft-off included

  // --------------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------------
  reg [2:0] next_state;
  reg       last_on;
  reg       ev_wake;
  reg       ev_sleep;
  reg       ev_force;

  always @* begin
    next_state = pwr_state;
    ev_wake    = 1'b0;
    ev_sleep   = 1'b0;
    ev_force   = 1'b0;
    case (pwr_state)
      `BPSS_ST_G3: begin
        if (ac_lvl) begin
          ev_wake    = restore_on && last_on;
          next_state = ev_wake ? `BPSS_ST_S0 : `BPSS_ST_S5;
        end
      end
      `BPSS_ST_S0: begin
        if (sw_long) begin
          next_state = `BPSS_ST_S5;
          ev_force   = 1'b1;
        end else if (sw_rel) begin
          next_state = sleep_sel_s3 ? `BPSS_ST_S3 : `BPSS_ST_S5;
          ev_sleep   = 1'b1;
        end
      end
      `BPSS_ST_S3, `BPSS_ST_S4, `BPSS_ST_S5: begin
        if (sw_long) begin
          next_state = `BPSS_ST_S5;
          ev_force   = (pwr_state != `BPSS_ST_S5);
        end else if (wake_any) begin
          next_state = `BPSS_ST_S0;
          ev_wake    = 1'b1;
        end
      end
      default: next_state = `BPSS_ST_G3;
    endcase
    if (!ac_lvl)
      next_state = `BPSS_ST_G3;
  end

  // state register, remembered on/off level and usb block after ac loss
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pwr_state <= `BPSS_ST_G3;
      last_on   <= 1'b0;
      usb_blk   <= 1'b1;
    end else begin
      pwr_state <= next_state;
      if (pwr_state != `BPSS_ST_G3)
        last_on <= (pwr_state == `BPSS_ST_S0);
      if (pwr_state == `BPSS_ST_G3)
        usb_blk <= 1'b1;
      else if (next_state == `BPSS_ST_S0)
        usb_blk <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // power and indicator outputs
  // --------------------------------------------------------------------------
  // cold boot only when leaving soft-off or mechanical-off; S3 resumes warm
  always @(posedge clk_sys) begin
    if (!nrst) begin
      main_pwr_en <= 1'b0;
      cold_boot   <= 1'b0;
      display_on  <= 1'b0;
      led_green   <= 1'b0;
      led_amber   <= 1'b0;
      led_stby    <= 1'b0;
    end else begin
      main_pwr_en <= (next_state == `BPSS_ST_S0);
      led_green   <= (next_state == `BPSS_ST_S0);
      led_amber   <= (next_state == `BPSS_ST_S3) && led_dual;
      led_stby    <= ac_lvl;
      if (next_state == `BPSS_ST_S0 && pwr_state != `BPSS_ST_S0) begin
        cold_boot  <= (pwr_state != `BPSS_ST_S3);
        display_on <= !(wk_rise[1] && wake_any);
      end else if (next_state != `BPSS_ST_S0) begin
        cold_boot  <= 1'b0;
        display_on <= 1'b0;
      end else if (sw_rel) begin
        display_on <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status, mask and register reads
  // --------------------------------------------------------------------------
  reg  [`BPSS_EV_NUM-1:0] int_stat;
  reg  [`BPSS_EV_NUM-1:0] int_mask;
  wire [`BPSS_EV_NUM-1:0] ev_set;
  assign ev_set = {ev_force, ev_sleep, ev_wake};

  // set wins over a write-one clear in the same cycle so no event is lost
  always @(posedge clk_sys) begin
    if (!nrst) begin
      int_stat <= 3'h0;
      int_mask <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == OFS_STAT)
        int_stat <= (int_stat & ~reg_wdata[2:0]) | ev_set;
      else
        int_stat <= int_stat | ev_set;
      if (reg_wr && reg_addr == OFS_MASK)
        int_mask <= reg_wdata[2:0];
    end
  end
  assign irq = |(int_stat & int_mask);

  // read data stand one cycle after the strobe; unmapped reads as zero
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_STAT:  reg_rdata <= {5'h00, int_stat};
        OFS_MASK:  reg_rdata <= {5'h00, int_mask};
        OFS_STATE: reg_rdata <= {3'h0, usb_blk, last_on, pwr_state};
        default:   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // bpss_seq

// ===== dv/bpss_seq_checker.sv
// checker for the board power state sequencer, port relations only
// assumes it is bound to bpss_seq and that everything runs on clk_sys
`timescale 1ns/100ps
`include "bpss_map.vh"
module bpss_seq_checker (
  // pins watched
  input wire logic       clk_sys, nrst, ac_ok, rtc_alarm, lan_wake, usb_wake,
  input wire logic       usb_deep_en, led_dual, reg_wr, reg_rd, irq, main_pwr_en,
  input wire logic       cold_boot, display_on, led_green, led_amber, led_stby,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [2:0] pwr_state
);
  // ----------------------------------------------------------------
  // relations between causes and indicators
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // sleeping with a dual-colour lamp fitted
  sequence s3_dual; pwr_state == `BPSS_ST_S3 && led_dual; endsequence
  // network wake seen while suspended
  sequence lan_up; pwr_state == `BPSS_ST_S3 && $rose(lan_wake); endsequence
  main_only_a: assert property (main_pwr_en |-> pwr_state == `BPSS_ST_S0)
    else $error("main power on outside working state");
  amber_a: assert property (s3_dual ##1 s3_dual |-> led_amber)
    else $error("amber lamp dark in suspend");
  lan_wake_a: assert property (lan_up |-> ##[1:12] pwr_state == `BPSS_ST_S0 && !cold_boot)
    else $error("network wake did not resume from suspend");
  alarm_a: assert property (pwr_state == `BPSS_ST_S5 && $rose(rtc_alarm)
    |-> ##[1:12] pwr_state == `BPSS_ST_S0 && !display_on)
    else $error("alarm wake missing or display forced on");
  usb_deep_a: assert property (pwr_state == `BPSS_ST_S5 && !usb_deep_en && $rose(usb_wake)
    |-> ##1 (pwr_state == `BPSS_ST_S5) [*8])
    else $error("usb woke from soft off while not enabled");
  idle_a: assert property (pwr_state == `BPSS_ST_S0 && $rose(lan_wake)
    |-> ##1 (pwr_state == `BPSS_ST_S0) [*8])
    else $error("wake while working changed state");
  stby_a: assert property (ac_ok [*8] |-> led_stby)
    else $error("standby lamp dark with power present");
  rd_zero_a: assert property (!reg_rd || reg_addr > 4'h2 |=> reg_rdata == 8'h00)
    else $error("read data outside a mapped read");
  state_rd_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[2:0] == $past(pwr_state))
    else $error("state register differs from pins");
  irq_mask_a: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt with all sources masked");
endmodule // bpss_seq_checker

bind bpss_seq bpss_seq_checker bpss_seq_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .ac_ok(ac_ok), .rtc_alarm(rtc_alarm),
  .lan_wake(lan_wake), .usb_wake(usb_wake), .usb_deep_en(usb_deep_en),
  .led_dual(led_dual), .reg_wr(reg_wr), .reg_rd(reg_rd), .irq(irq),
  .main_pwr_en(main_pwr_en), .cold_boot(cold_boot), .display_on(display_on),
  .led_green(led_green), .led_amber(led_amber), .led_stby(led_stby),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pwr_state(pwr_state));

// ===== dv/bpss_far.sv
// far side model: power switch, wake sources and ac supply
// assumes the bench calls its tasks; all pins move just after a rising edge
`timescale 1ns/100ps
module bpss_far (
  // clock
  input  wire clk_sys,
  // pins toward the sequencer
  output reg  pwr_sw_n, rtc_alarm, lan_wake, usb_wake, pcie_wake_n, ac_ok
);
  // idle: switch open on its pull-up, no wake, supply present
  initial {pwr_sw_n, rtc_alarm, lan_wake, usb_wake, pcie_wake_n, ac_ok} = 6'b100011;
  // switch held n cycles; long enough to clear the debounce
  task press(input int n);
    @(posedge clk_sys) pwr_sw_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    pwr_sw_n <= 1'b1;
  endtask
  // wake source k held 10 cycles: 1 alarm, 2 network frame, 3 usb, 4 pcie
  task wake(input int k);
    @(posedge clk_sys);
    rtc_alarm <= (k == 1);
    lan_wake <= (k == 2);
    usb_wake <= (k == 3);
    pcie_wake_n <= (k != 4);
    repeat (10) @(posedge clk_sys);
    {rtc_alarm, lan_wake, usb_wake, pcie_wake_n} <= 4'b0001;
  endtask
  // supply loss and return
  task ac(input bit v);
    @(posedge clk_sys) ac_ok <= v;
  endtask
endmodule // bpss_far

// ===== dv/bpss_seq_bench.sv
// self-checking bench for the board power state sequencer
// assumes bpss_seq, bpss_far and the bound checker; reads queue their expectations
`timescale 1ns/100ps
`include "bpss_map.vh"
module bpss_seq_bench;
  logic       clk_sys = 0, nrst = 0, sleep_sel_s3 = 0, usb_deep_en = 1, restore_on = 0;
  logic       led_dual = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  wire        pwr_sw_n, rtc_alarm, lan_wake, usb_wake, pcie_wake_n, ac_ok, irq;
  wire        main_pwr_en, cold_boot, display_on, led_green, led_amber, led_stby;
  wire  [7:0] reg_rdata;
  wire  [2:0] pwr_state;
  wire [15:0] obs = {reg_rdata, 1'b0, main_pwr_en, cold_boot, display_on, led_green,
                     led_amber, led_stby, irq};
  int         n_mismatch = 0, n_compared = 0;
  logic [31:0] q[$]; // expected value and care mask
  bpss_seq bpss_seq_inst (
    .clk_sys(clk_sys), .nrst(nrst), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm),
    .lan_wake(lan_wake), .usb_wake(usb_wake), .pcie_wake_n(pcie_wake_n), .ac_ok(ac_ok),
    .sleep_sel_s3(sleep_sel_s3), .usb_deep_en(usb_deep_en), .restore_on(restore_on),
    .led_dual(led_dual), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pwr_state(pwr_state),
    .main_pwr_en(main_pwr_en), .cold_boot(cold_boot), .display_on(display_on),
    .led_green(led_green), .led_amber(led_amber), .led_stby(led_stby));
  bpss_far bpss_far_inst (
    .clk_sys(clk_sys), .pwr_sw_n(pwr_sw_n), .rtc_alarm(rtc_alarm), .lan_wake(lan_wake),
    .usb_wake(usb_wake), .pcie_wake_n(pcie_wake_n), .ac_ok(ac_ok));
  always #4 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // register port and checks
  // ----------------------------------------------------------------
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e, input [15:0] m);
    q.push_back({e, m});
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // state register plus lamps; display only matters while working, cold is expected low otherwise
  task look(input [2:0] s, input c, input d);
    logic on;
    on = (s == `BPSS_ST_S0);
    rd(4'h2, {5'h00, s, 1'b0, on, c & on, d, on, led_dual & (s == `BPSS_ST_S3), ac_ok, 1'b0},
       {8'h07, 7'h3F, 1'b0} & ~{11'h0, !on, 4'h0});
  endtask
  // short press, then room for debounce and release handling
  task tap();
    bpss_far_inst.press(2000);
    repeat (1500) @(posedge clk_sys);
  endtask
  task up(input int k);
    if (k == 0) tap(); else bpss_far_inst.wake(k);
    repeat (20) @(posedge clk_sys);
  endtask
  // read data stand one cycle: compare against the oldest note then
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      n_compared++;
      if (q.size() == 0 || ((obs ^ q[0][31:16]) & q[0][15:0]) !== 16'h0000) begin
        n_mismatch++;
        $display("Error at %0t: read gave %h", $time, obs);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard: about 50k cycles expected
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic s3;
    void'($urandom(27487));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    look(`BPSS_ST_S5, 0, 0);
    rd(4'h9, 16'h0000, 16'hFF00);
    wr(4'h2, 8'hFF);
    wr(4'h1, 8'h07);
    rd(4'h1, 16'h0700, 16'hFF00);
    up(0);
    look(`BPSS_ST_S0, 1, 1);
    // every wake source from both sleep depths, lamp type partly random
    for (int k = 0; k < 10; k++) begin
      s3 = k[0];
      led_dual <= k[1] | 1'($urandom());
      sleep_sel_s3 <= s3;
      tap();
      look(s3 ? `BPSS_ST_S3 : `BPSS_ST_S5, 0, 0);
      up(k / 2);
      look(`BPSS_ST_S0, !s3, k / 2 != 1);
    end
    rd(4'h0, 16'h0101, 16'h0101);
    wr(4'h0, 8'h07);
    rd(4'h0, 16'h0000, 16'h0701);
    wr(4'h1, 8'h00);
    up(2);
    look(`BPSS_ST_S0, 0, 1);
    {sleep_sel_s3, usb_deep_en} <= 2'b00;
    tap();
    rd(4'h0, 16'h0200, 16'h0201);
    up(3);
    look(`BPSS_ST_S5, 0, 0);
    {usb_deep_en, restore_on} <= 2'b11;
    up(4);
    look(`BPSS_ST_S0, 1, 1);
    for (int r = 1; r >= 0; r--) begin
      restore_on <= r[0];
      bpss_far_inst.ac(0);
      repeat (20) @(posedge clk_sys);
      look(`BPSS_ST_G3, 0, 0);
      bpss_far_inst.ac(1);
      repeat (30) @(posedge clk_sys);
      look(r ? `BPSS_ST_S0 : `BPSS_ST_S5, 1, 1);
    end
    up(3);
    look(`BPSS_ST_S5, 0, 0);
    up(2);
    look(`BPSS_ST_S0, 1, 1);
    repeat (5) @(posedge clk_sys);
    end_of_test();
  end
endmodule // bpss_seq_bench
